/* core/aag_pkg.sv */
package aag_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] AAG_IDX_IRQ_STATUS = 8'h00;
  localparam logic [7:0] AAG_IDX_IRQ_CLEAR = 8'h01;
  localparam logic [7:0] AAG_IDX_IRQ_ENABLE = 8'h02;
  localparam logic [7:0] AAG_IDX_PIN_MODE = 8'h03;
  localparam logic [7:0] AAG_IDX_IO_PORT_CONFIG = 8'h0e;
  localparam logic [7:0] AAG_IDX_ADC_CONFIG = 8'h0f;
  localparam logic [7:0] AAG_IDX_ADC_AMP_OFFSET = 8'h10;
  localparam logic [7:0] AAG_IDX_ADC_RESULT = 8'h11;
  localparam logic [7:0] AAG_IDX_TEMP_SENSOR_CAL = 8'h12;

  localparam logic [7:0] AAG_ADDR_IRQ_STATUS = 8'(AAG_IDX_IRQ_STATUS * 4);
  localparam logic [7:0] AAG_ADDR_IRQ_CLEAR = 8'(AAG_IDX_IRQ_CLEAR * 4);
  localparam logic [7:0] AAG_ADDR_IRQ_ENABLE = 8'(AAG_IDX_IRQ_ENABLE * 4);
  localparam logic [7:0] AAG_ADDR_PIN_MODE = 8'(AAG_IDX_PIN_MODE * 4);
  localparam logic [7:0] AAG_ADDR_IO_PORT_CONFIG = 8'(AAG_IDX_IO_PORT_CONFIG * 4);
  localparam logic [7:0] AAG_ADDR_ADC_CONFIG = 8'(AAG_IDX_ADC_CONFIG * 4);
  localparam logic [7:0] AAG_ADDR_ADC_AMP_OFFSET = 8'(AAG_IDX_ADC_AMP_OFFSET * 4);
  localparam logic [7:0] AAG_ADDR_ADC_RESULT = 8'(AAG_IDX_ADC_RESULT * 4);
  localparam logic [7:0] AAG_ADDR_TEMP_SENSOR_CAL = 8'(AAG_IDX_TEMP_SENSOR_CAL * 4);

  // field positions
  localparam int AAG_ITSDO_BIT = 3;
  localparam int AAG_EXTST_LSB = 4;
  localparam int AAG_ADC_START_BIT = 7;
  localparam int AAG_ADC_SEL_LSB = 4;
  localparam int AAG_ADC_REF_LSB = 2;
  localparam int AAG_ADC_GAIN_LSB = 0;
  localparam int AAG_OFFS_SIGN_BIT = 3;
  localparam int AAG_TS_RANGE_LSB = 6;
  localparam int AAG_TS_KOFFS_BIT = 5;
  localparam int AAG_TS_TRIM_EN_BIT = 4;
  localparam int AAG_TS_TRIM_LSB = 0;
  localparam int AAG_IRQ_ADC_BIT = 0;
  localparam int AAG_IRQ_EXT_LSB = 1;

  // values after reset
  localparam logic [3:0] AAG_IRQ_RST = 4'h0;
  localparam logic [5:0] AAG_PIN_MODE_RST = 6'h00;
  localparam logic [3:0] AAG_IO_PORT_RST = 4'h0;
  localparam logic [6:0] AAG_ADC_CONFIG_RST = 7'h00;
  localparam logic [3:0] AAG_ADC_OFFS_RST = 4'h0;
  localparam logic [7:0] AAG_ADC_RESULT_RST = 8'h00;
  localparam logic [7:0] AAG_TS_CAL_RST = 8'h20;

  typedef enum logic [1:0] {
    AAG_PIN_IN = 2'h0,
    AAG_PIN_OUT = 2'h1,
    AAG_PIN_EXTI = 2'h2,
    AAG_PIN_ANALOG = 2'h3
  } aag_pin_mode_e;

  typedef enum logic [1:0] {
    AAG_ADC_IDLE = 2'h0,
    AAG_ADC_BUSY = 2'h1,
    AAG_ADC_DONE = 2'h3
  } aag_adc_state_e;

  typedef struct packed {
    logic src_temp;
    logic src_gnd;
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
    logic diff;
    logic ref_bandgap;
    logic ref_vdd_div3;
    logic ref_vdd_div2;
    logic [2:0] gain_mult;
    logic fs_coef_hi;
    logic signed [3:0] offset_milli;
  } aag_adc_ctl_s;

  typedef struct packed {
    logic [1:0] range;
    logic fahrenheit;
    logic half_step;
    logic zero_base;
    logic kelvin_offset_en;
    logic trim_en;
    logic [3:0] trim;
  } aag_ts_ctl_s;

endpackage

/* core/aag_pin_cell.sv */
`timescale 1ns/10ps
`default_nettype none

module aag_pin_cell
  import aag_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire aag_pkg::aag_pin_mode_e mode,
  input wire logic out_val,
  // pad
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  // status
  output logic level,
  output logic ext_event
);
  logic prev_reg;

  // pad value comes straight from the direct output bit flop
  assign pin_o = out_val;
  assign pin_oe = (mode == AAG_PIN_OUT);
  assign level = pin_i;
  // rising edge only counts while the pin is an interrupt source
  assign ext_event = (mode == AAG_PIN_EXTI) && pin_i && !prev_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_i;
    end
  end

endmodule

`default_nettype wire

/* core/aag_aux_ctrl.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Function
// - irq on data out while select high
// - pin interrupt status bits 6..4 readable
// - output pins follow direct io bits
// - input pins read back live level
// - start bit launches, reads done
// - input select decodes adc source
// - reference select decodes adc reference
// - differential gain sets full scale multiplier
// - offset field is sign and magnitude
// - offset field resets to zero
// - read-only eight bit result register
// - range field selects sensor span
// - kelvin to celsius offset enable
// - trim enable applies four bit trim
// - calibration register resets to 0x20
module aag_aux_ctrl
  import aag_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NPINS = 3
)(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // interrupt
  output logic IRQ,
  // serial data out sharing
  input wire logic CHIP_SELECT_N,
  input wire logic SPI_SDO_O,
  input wire logic SPI_SDO_OE,
  output logic SDO_O,
  output logic SDO_OE,
  // general purpose pins
  input wire logic [NPINS-1:0] AUX_PIN_I,
  output logic [NPINS-1:0] AUX_PIN_O,
  output logic [NPINS-1:0] AUX_PIN_OE,
  // converter handshake
  output logic ADC_CONV_REQ,
  input wire logic ADC_CONV_DONE,
  input wire logic [7:0] ADC_CONV_DATA,
  output aag_pkg::aag_adc_ctl_s ADC_CTL,
  // temperature sensor
  output aag_pkg::aag_ts_ctl_s TS_CTL
);
  import aag_pkg::*;

  logic [3:0] irq_status_reg;
  logic [3:0] irq_status_next;
  logic [3:0] irq_enable_reg;
  logic [5:0] pin_mode_reg;
  logic [3:0] io_port_reg;
  logic [6:0] adc_cfg_reg;
  logic [3:0] adc_offs_reg;
  logic [7:0] adc_result_reg;
  logic [7:0] ts_cal_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_data;
  aag_adc_state_e adc_state_reg;
  aag_adc_state_e adc_state_next;

  logic [NPINS-1:0] pin_level;
  logic [NPINS-1:0] pin_event;
  logic [NPINS-1:0] pin_is_in;
  logic [NPINS-1:0] dio_read;
  logic [3:0] irq_events;
  logic [2:0] sel;
  logic [1:0] refsel;
  logic [1:0] tsr;

  // address decode
  wire hit_status = (PADDR == ADDR_W'(AAG_ADDR_IRQ_STATUS));
  wire hit_clear = (PADDR == ADDR_W'(AAG_ADDR_IRQ_CLEAR));
  wire hit_enable = (PADDR == ADDR_W'(AAG_ADDR_IRQ_ENABLE));
  wire hit_mode = (PADDR == ADDR_W'(AAG_ADDR_PIN_MODE));
  wire hit_io = (PADDR == ADDR_W'(AAG_ADDR_IO_PORT_CONFIG));
  wire hit_adc = (PADDR == ADDR_W'(AAG_ADDR_ADC_CONFIG));
  wire hit_offs = (PADDR == ADDR_W'(AAG_ADDR_ADC_AMP_OFFSET));
  wire hit_result = (PADDR == ADDR_W'(AAG_ADDR_ADC_RESULT));
  wire hit_ts = (PADDR == ADDR_W'(AAG_ADDR_TEMP_SENSOR_CAL));
  wire mapped = hit_status | hit_clear | hit_enable | hit_mode | hit_io | hit_adc | hit_offs | hit_result | hit_ts;

  // no wait state: read data is latched in setup so it leaves a flop
  wire setup_rd = PSEL && !PENABLE && !PWRITE;
  wire access = PSEL && PENABLE;
  wire wr_en = access && PWRITE && mapped;
  wire [7:0] wd = PWDATA[7:0];

  assign PREADY = access;
  assign PSLVERR = access && !mapped;
  assign PRDATA = prdata_reg;

  // pins
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : pin
      aag_pin_cell u_cell (
        .clk(CLK),
        .rst_n(RST_N),
        .mode(aag_pin_mode_e'(pin_mode_reg[2*g +: 2])),
        .out_val(io_port_reg[g]),
        .pin_i(AUX_PIN_I[g]),
        .pin_o(AUX_PIN_O[g]),
        .pin_oe(AUX_PIN_OE[g]),
        .level(pin_level[g]),
        .ext_event(pin_event[g])
      );
      assign pin_is_in[g] = (pin_mode_reg[2*g +: 2] == AAG_PIN_IN);
      // inputs read the pad, other modes read the stored bit
      assign dio_read[g] = pin_is_in[g] ? pin_level[g] : io_port_reg[g];
    end
  endgenerate

  // interrupts
  wire adc_finish = (adc_state_reg == AAG_ADC_BUSY) && ADC_CONV_DONE;
  wire [3:0] clr_mask = (wr_en && hit_clear) ? wd[3:0] : 4'h0;
  assign irq_events = {pin_event, adc_finish};
  // an event in the clearing cycle survives the clear
  assign irq_status_next = (irq_status_reg & ~clr_mask) | irq_events;
  assign IRQ = |(irq_status_reg & irq_enable_reg);

  // serial data out: the active low request takes the pin between frames
  wire irq_on_sdo = io_port_reg[AAG_ITSDO_BIT] && CHIP_SELECT_N;
  assign SDO_O = irq_on_sdo ? !IRQ : SPI_SDO_O;
  assign SDO_OE = irq_on_sdo ? 1'b1 : SPI_SDO_OE;

  // adc sequencer
  wire start_wr = wr_en && hit_adc && wd[AAG_ADC_START_BIT];
  always_comb begin
    adc_state_next = adc_state_reg;
    case (adc_state_reg)
      AAG_ADC_IDLE: begin
        if (start_wr) begin
          adc_state_next = AAG_ADC_BUSY;
        end
      end
      AAG_ADC_BUSY: begin
        if (ADC_CONV_DONE) begin
          adc_state_next = AAG_ADC_DONE;
        end
      end
      AAG_ADC_DONE: begin
        if (start_wr) begin
          adc_state_next = AAG_ADC_BUSY;
        end
      end
      default: begin
        adc_state_next = AAG_ADC_IDLE;
      end
    endcase
  end
  // a start while busy is ignored; the running conversion is not restarted
  assign ADC_CONV_REQ = (adc_state_reg == AAG_ADC_BUSY);
  wire adc_done = (adc_state_reg == AAG_ADC_DONE);

  // adc source decode
  assign sel = adc_cfg_reg[AAG_ADC_SEL_LSB +: 3];
  assign ADC_CTL.src_temp = (sel == 3'h0);
  assign ADC_CTL.src_gnd = (sel == 3'h7);
  assign ADC_CTL.diff = (sel == 3'h4) || (sel == 3'h5) || (sel == 3'h6);
  assign ADC_CTL.pos_sel = (sel == 3'h1 || sel == 3'h4 || sel == 3'h6) ? 3'h1 :
                           (sel == 3'h2 || sel == 3'h5) ? 3'h2 :
                           (sel == 3'h3) ? 3'h4 : 3'h0;
  assign ADC_CTL.neg_sel = (sel == 3'h4) ? 3'h2 :
                           (sel == 3'h5 || sel == 3'h6) ? 3'h4 : 3'h0;

  // reference decode
  assign refsel = adc_cfg_reg[AAG_ADC_REF_LSB +: 2];
  assign ADC_CTL.ref_bandgap = !refsel[1];
  assign ADC_CTL.ref_vdd_div3 = (refsel == 2'h2);
  assign ADC_CTL.ref_vdd_div2 = (refsel == 2'h3);

  // full scale = coef x (gain+1) x supply, only meaningful in differential mode
  assign ADC_CTL.gain_mult = ADC_CTL.diff ? 3'(adc_cfg_reg[AAG_ADC_GAIN_LSB +: 2]) + 3'h1 : 3'h1;
  assign ADC_CTL.fs_coef_hi = refsel[0];

  // sign and magnitude turned into two's complement thousandths of supply
  wire [3:0] offs_mag = {1'b0, adc_offs_reg[2:0]};
  assign ADC_CTL.offset_milli = adc_offs_reg[AAG_OFFS_SIGN_BIT] ? -$signed(offs_mag) : $signed(offs_mag);

  // temperature sensor controls
  assign tsr = ts_cal_reg[AAG_TS_RANGE_LSB +: 2];
  assign TS_CTL.range = tsr;
  assign TS_CTL.fahrenheit = (tsr == 2'h2);
  assign TS_CTL.half_step = (tsr == 2'h0) || (tsr == 2'h3);
  assign TS_CTL.zero_base = (tsr == 2'h3);
  assign TS_CTL.kelvin_offset_en = ts_cal_reg[AAG_TS_KOFFS_BIT];
  assign TS_CTL.trim_en = ts_cal_reg[AAG_TS_TRIM_EN_BIT];
  assign TS_CTL.trim = TS_CTL.trim_en ? ts_cal_reg[AAG_TS_TRIM_LSB +: 4] : 4'h0;

  // read mux; reserved bits read zero
  assign rd_data =
    hit_status ? {28'h0, irq_status_reg} :
    hit_enable ? {28'h0, irq_enable_reg} :
    hit_mode ? {26'h0, pin_mode_reg} :
    hit_io ? {24'h0, 1'b0, irq_status_reg[AAG_IRQ_EXT_LSB +: 3], io_port_reg[3], dio_read} :
    hit_adc ? {24'h0, adc_done, adc_cfg_reg} :
    hit_offs ? {28'h0, adc_offs_reg} :
    hit_result ? {24'h0, adc_result_reg} :
    hit_ts ? {24'h0, ts_cal_reg} :
    32'h0;

  // state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      adc_state_reg <= AAG_ADC_IDLE;
      irq_status_reg <= AAG_IRQ_RST;
      prdata_reg <= 32'h0;
    end else begin
      adc_state_reg <= adc_state_next;
      irq_status_reg <= irq_status_next;
      if (setup_rd) begin
        prdata_reg <= rd_data;
      end
    end
  end

  // result loads in the same edge that moves to done
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      adc_result_reg <= AAG_ADC_RESULT_RST;
    end else if (adc_finish) begin
      adc_result_reg <= ADC_CONV_DATA;
    end
  end

  // software registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_enable_reg <= AAG_IRQ_RST;
      pin_mode_reg <= AAG_PIN_MODE_RST;
      io_port_reg <= AAG_IO_PORT_RST;
      adc_cfg_reg <= AAG_ADC_CONFIG_RST;
      adc_offs_reg <= AAG_ADC_OFFS_RST;
      ts_cal_reg <= AAG_TS_CAL_RST;
    end else if (wr_en) begin
      if (hit_enable) begin
        irq_enable_reg <= wd[3:0];
      end else if (hit_mode) begin
        pin_mode_reg <= wd[5:0];
      end else if (hit_io) begin
        io_port_reg <= wd[3:0];
      end else if (hit_adc) begin
        adc_cfg_reg <= wd[6:0];
      end else if (hit_offs) begin
        adc_offs_reg <= wd[3:0];
      end else if (hit_ts) begin
        ts_cal_reg <= wd;
      end
    end
  end

endmodule

`default_nettype wire

/* verif/aag_conv_model.sv */
`timescale 1ns/10ps
`default_nettype none
module aag_conv_model (
  // clock
  input wire logic clk,
  // converter handshake
  input wire logic req,
  output logic done,
  output logic [7:0] data,
  // bench control
  input wire logic [7:0] lat,
  input wire logic [7:0] val
);
  int n = 0;
  initial begin
    done = 1'b0;
    data = 8'h00;
  end
  always @(posedge clk) begin
    n <= req ? n + 1 : 0;
    done <= 1'b0;
    // stale data flips so nothing leans on it
    data <= ~data;
    if (req && !done && n >= int'(lat)) begin
      done <= 1'b1;
      data <= val;
    end
  end
endmodule
`default_nettype wire

/* verif/aag_aux_ctrl_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module aag_aux_ctrl_monitor
  import aag_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NPINS = 3
)(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // irq and serial out
  input wire logic IRQ,
  input wire logic CHIP_SELECT_N,
  input wire logic SPI_SDO_O,
  input wire logic SPI_SDO_OE,
  input wire logic SDO_O,
  input wire logic SDO_OE,
  // pins
  input wire logic [NPINS-1:0] AUX_PIN_I,
  input wire logic [NPINS-1:0] AUX_PIN_O,
  input wire logic [NPINS-1:0] AUX_PIN_OE,
  // converter
  input wire logic ADC_CONV_REQ,
  input wire logic ADC_CONV_DONE,
  input wire logic [7:0] ADC_CONV_DATA,
  input wire aag_pkg::aag_adc_ctl_s ADC_CTL,
  input wire aag_pkg::aag_ts_ctl_s TS_CTL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire io_wr = PSEL && PENABLE && PWRITE && PADDR == ADDR_W'(AAG_ADDR_IO_PORT_CONFIG);
  sdo_pass_a: assert property (!CHIP_SELECT_N |-> SDO_O == SPI_SDO_O && SDO_OE == SPI_SDO_OE)
    else $error("sdo not passed through");
  sdo_irq_a: assert property (CHIP_SELECT_N && SDO_O != SPI_SDO_O |-> SDO_O == !IRQ && SDO_OE)
    else $error("sdo not irq");
  pin_hold_a: assert property ($changed(AUX_PIN_O) |-> $past(io_wr))
    else $error("pin out moved alone");
  req_hold_a: assert property (ADC_CONV_REQ && !ADC_CONV_DONE |=> ADC_CONV_REQ)
    else $error("req dropped early");
  req_drop_a: assert property (ADC_CONV_REQ && ADC_CONV_DONE |=> !ADC_CONV_REQ)
    else $error("req held after done");
  diff_pair_a: assert property (ADC_CTL.diff |-> $onehot(ADC_CTL.pos_sel) && $onehot(ADC_CTL.neg_sel))
    else $error("bad pair");
  trim_off_a: assert property (!TS_CTL.trim_en |-> TS_CTL.trim == 4'h0)
    else $error("trim leaks");
  cal_reset_a: assert property ($rose(RST_N) |-> TS_CTL.kelvin_offset_en && TS_CTL.range == 2'h0)
    else $error("cal reset");
  cover property (ADC_CONV_REQ && ADC_CONV_DONE);
  cover property (CHIP_SELECT_N && SDO_OE && !SPI_SDO_OE);
  cover property ($rose(IRQ));
endmodule
bind aag_aux_ctrl aag_aux_ctrl_monitor #(.ADDR_W(ADDR_W), .NPINS(NPINS)) mon_u (.*);
`default_nettype wire

/* verif/aag_aux_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module aag_aux_ctrl_tb;
  import aag_pkg::*;
  logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, IRQ;
  logic CHIP_SELECT_N = 1, SPI_SDO_O = 0, SPI_SDO_OE = 0, SDO_O, SDO_OE;
  logic ADC_CONV_REQ, ADC_CONV_DONE, err;
  logic [7:0] PADDR = 0, ADC_CONV_DATA, lat = 0, val = 0;
  logic [31:0] PWDATA = 0, PRDATA, r, v;
  logic [2:0] AUX_PIN_I = 0, AUX_PIN_O, AUX_PIN_OE, s;
  aag_adc_ctl_s ADC_CTL, e;
  aag_ts_ctl_s TS_CTL;
  int bad_count = 0, cmp_count = 0, seed = 32'h7889, cyc = 0;
  logic [7:0] q[$];
  aag_aux_ctrl dut_u (.*);
  aag_conv_model cm_u (.clk(CLK), .req(ADC_CONV_REQ), .done(ADC_CONV_DONE), .data(ADC_CONV_DATA),
    .lat(lat), .val(val));
  initial forever #5 CLK = ~CLK;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task automatic tend(input string n);
    $display("test %s over", n);
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, well above the run length
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge CLK);
    RST_N <= 1;
    xfer(0, AAG_ADDR_TEMP_SENSOR_CAL, 0);
    chk(r, 32'h20);
    xfer(0, AAG_ADDR_ADC_AMP_OFFSET, 0);
    chk(r, 32'h0);
    xfer(0, 8'hfc, 0);
    chk({err, r[30:0]}, 32'h80000000);
    tend("reset");
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      xfer(1, AAG_ADDR_ADC_AMP_OFFSET, v);
      xfer(0, AAG_ADDR_ADC_AMP_OFFSET, 0);
      chk(r, v & 32'hf);
      xfer(1, AAG_ADDR_TEMP_SENSOR_CAL, v);
      #1;
      chk({TS_CTL.range, TS_CTL.fahrenheit, TS_CTL.kelvin_offset_en, TS_CTL.trim},
        {v[7:6], v[7:6] == 2'h2, v[5], v[4] ? v[3:0] : 4'h0});
      chk({TS_CTL.half_step, TS_CTL.zero_base, TS_CTL.trim_en},
        {v[7:6] == 2'h0 || v[7:6] == 2'h3, v[7:6] == 2'h3, v[4]});
      // sign and magnitude: the sign bit negates the three magnitude bits
      chk(32'(ADC_CTL.offset_milli), 32'(v[3] ? 4'h0 - {1'b0, v[2:0]} : {1'b0, v[2:0]}));
    end
    tend("sensor");
    for (int i = 0; i < 128; i++) begin
      xfer(1, AAG_ADDR_ADC_CONFIG, i);
      #1;
      s = 3'(i >> 4);
      e = '0;
      e.src_temp = s == 0;
      e.src_gnd = s == 7;
      e.diff = s inside {4, 5, 6};
      e.pos_sel = s inside {1, 4, 6} ? 3'h1 : s inside {2, 5} ? 3'h2 : s == 3 ? 3'h4 : 3'h0;
      e.neg_sel = s == 4 ? 3'h2 : s inside {5, 6} ? 3'h4 : 3'h0;
      e.ref_bandgap = !i[3];
      e.ref_vdd_div3 = i[3:2] == 2'h2;
      e.ref_vdd_div2 = i[3:2] == 2'h3;
      e.gain_mult = e.diff ? 3'(i[1:0]) + 3'h1 : 3'h1;
      e.fs_coef_hi = i[2];
      chk(32'(ADC_CTL[19:4]), 32'(e[19:4]));
    end
    tend("config");
    xfer(1, AAG_ADDR_IRQ_ENABLE, 32'h1);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      lat <= 8'(i * 9);
      val <= v[7:0];
      q.push_back(v[7:0]);
      xfer(1, AAG_ADDR_ADC_CONFIG, 32'h80 | (i << 4));
      r = 0;
      for (int k = 0; k < 60 && !r[7]; k++) xfer(0, AAG_ADDR_ADC_CONFIG, 0);
      chk(r[7], 1);
      xfer(1, AAG_ADDR_ADC_RESULT, ~v);
      xfer(0, AAG_ADDR_ADC_RESULT, 0);
      chk(r, q.pop_front());
      chk(IRQ, 1);
      xfer(1, AAG_ADDR_IRQ_CLEAR, 32'h1);
      #1;
      chk(IRQ, 0);
    end
    tend("adc");
    xfer(1, AAG_ADDR_PIN_MODE, 32'h15);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      xfer(1, AAG_ADDR_IO_PORT_CONFIG, v & 32'h7);
      #1;
      chk({AUX_PIN_OE, AUX_PIN_O}, {3'h7, v[2:0]});
    end
    xfer(1, AAG_ADDR_PIN_MODE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      AUX_PIN_I <= v[2:0];
      repeat (4) @(posedge CLK);
      xfer(0, AAG_ADDR_IO_PORT_CONFIG, 0);
      chk({AUX_PIN_OE, r[2:0]}, {3'h0, v[2:0]});
    end
    // edge mode: each pin alone, so a swapped bit shows
    xfer(1, AAG_ADDR_PIN_MODE, 32'h2a);
    xfer(1, AAG_ADDR_IRQ_ENABLE, 32'he);
    for (int p = 0; p < 3; p++) begin
      AUX_PIN_I <= 0;
      xfer(1, AAG_ADDR_IRQ_CLEAR, 32'hf);
      AUX_PIN_I <= 3'(1 << p);
      repeat (4) @(posedge CLK);
      xfer(0, AAG_ADDR_IO_PORT_CONFIG, 0);
      chk({IRQ, r[6:4]}, {1'b1, 3'(1 << p)});
    end
    tend("pins");
    xfer(1, AAG_ADDR_IO_PORT_CONFIG, 32'h8);
    for (int j = 0; j < 2; j++) begin
      if (j == 1) xfer(1, AAG_ADDR_IRQ_CLEAR, 32'hf);
      for (int k = 0; k < 8; k++) begin
        v = $random(seed);
        CHIP_SELECT_N <= v[0];
        SPI_SDO_O <= v[1];
        SPI_SDO_OE <= v[2];
        @(posedge CLK);
        #1;
        chk({SDO_OE, SDO_O}, v[0] ? {1'b1, j[0]} : {v[2], v[1]});
      end
    end
    tend("sdo");
    conclude();
  end
endmodule
`default_nettype wire
